// ==== design/smv_pkg.sv ====
// Purpose: Shared constants for the set-point and output selection block
// Assumes: Output values in signed tenths of a percent, set points in signed EU counts
// Notes: Reset values follow the parameter defaults of the controller channel
package smv_pkg;

  // Data widths
  localparam int MV_W = 16;
  localparam int SP_W = 16;

  // Output setting ranges, tenths of a percent
  localparam logic signed [MV_W-1:0] MV_STD_MIN = 16'shFFCE;
  localparam logic signed [MV_W-1:0] MV_STD_MAX = 16'sh041A;
  localparam logic signed [MV_W-1:0] MV_HC_MIN = 16'shFBE6;
  localparam logic signed [MV_W-1:0] MV_HC_MAX = 16'sh041A;
  localparam logic signed [MV_W-1:0] MV_HC_SPLIT = 16'sh0000;

  // Reset values
  localparam logic signed [MV_W-1:0] HAND_RST = 16'sh0000;
  localparam logic signed [MV_W-1:0] HALTED_RST = 16'sh0000;
  localparam logic signed [MV_W-1:0] FAULT_RST = 16'sh0000;
  localparam logic signed [MV_W-1:0] CEILING_RST = 16'sh041A;
  localparam logic signed [MV_W-1:0] FLOOR_RST = 16'shFBE6;
  localparam logic signed [MV_W-1:0] MV_RST = 16'sh0000;
  localparam logic signed [SP_W-1:0] SP_RST = 16'sh0000;
  localparam logic FOLLOW_RST = 1'b0;

  // Control period timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CTRL_PERIOD_US = 100;
  localparam int CTRL_PERIOD_CYC = (CTRL_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // Saturate a value into [lo, hi]
  function automatic logic signed [MV_W-1:0] sat(
    input logic signed [MV_W-1:0] v,
    input logic signed [MV_W-1:0] lo,
    input logic signed [MV_W-1:0] hi
  );
    if (v < lo)
    begin
      return lo;
    end
    if (v > hi)
    begin
      return hi;
    end
    return v;
  endfunction

endpackage

// ==== design/smv_lim_if.sv ====
// Purpose: Carries one raw output and its limit pair to the limiter and back
// Assumes: Purely combinational path inside one clock domain
// Notes: hi and lo return the effective limits after ordering
`timescale 1ns/1ps
interface smv_lim_if;
  logic signed [smv_pkg::MV_W-1:0] raw;
  logic signed [smv_pkg::MV_W-1:0] ceiling;
  logic signed [smv_pkg::MV_W-1:0] floor;
  logic heatCool;
  logic signed [smv_pkg::MV_W-1:0] hi;
  logic signed [smv_pkg::MV_W-1:0] lo;
  logic signed [smv_pkg::MV_W-1:0] result;

  modport user (output raw, output ceiling, output floor, output heatCool,
                input hi, input lo, input result);
  modport lim (input raw, input ceiling, input floor, input heatCool,
               output hi, output lo, output result);
endinterface // smv_lim_if

// ==== design/smv_out_limit.sv ====
// Purpose: Clamps the calculated output between the configured limits
// Assumes: Limits may arrive out of order or out of range
// Notes: Combinational; the caller registers the result
`timescale 1ns/1ps
module smv_out_limit (
  // Limiter channel
  smv_lim_if.lim lim
);

  logic signed [smv_pkg::MV_W-1:0] ceilEff;
  logic signed [smv_pkg::MV_W-1:0] floorEff;

  always_comb
  begin
    // One pair covers the combined heating/cooling output
    if (lim.heatCool)
    begin
      ceilEff = smv_pkg::sat(lim.ceiling, smv_pkg::MV_HC_SPLIT, smv_pkg::MV_HC_MAX);
      floorEff = smv_pkg::sat(lim.floor, smv_pkg::MV_HC_MIN, smv_pkg::MV_HC_SPLIT);
    end
    else
    begin
      ceilEff = smv_pkg::sat(lim.ceiling, smv_pkg::MV_STD_MIN, smv_pkg::MV_STD_MAX);
      floorEff = smv_pkg::sat(lim.floor, smv_pkg::MV_STD_MIN, smv_pkg::MV_STD_MAX);
    end
    // Larger value acts as the upper limit
    if (floorEff > ceilEff)
    begin
      lim.hi = floorEff;
      lim.lo = ceilEff;
    end
    else
    begin
      lim.hi = ceilEff;
      lim.lo = floorEff;
    end
    lim.result = smv_pkg::sat(lim.raw, lim.lo, lim.hi);
  end

endmodule // smv_out_limit

// ==== design/smv_select.sv ====
// Purpose: Per-channel set-point source selection and output value selection
// Assumes: Process values, settings and commands come from logic on ref_clk
// Notes: Event pins are asynchronous and pass a three-stage synchroniser
`timescale 1ns/1ps
module smv_select #(
  parameter int PERIOD_CYC = smv_pkg::CTRL_PERIOD_CYC,
  parameter int CHANNEL = 1,
  parameter bit FOUR_CH = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Event input pins
  input wire logic evtSourcePin,
  input wire logic evtHandPin,
  // Event input assignment
  input wire logic evtSourceAssigned,
  input wire logic evtHandAssigned,
  // Operation commands
  input wire logic cmdRemote,
  input wire logic cmdHand,
  input wire logic runCmd,
  // Configuration
  input wire logic remoteEnable,
  input wire logic rampEnable,
  input wire logic twoDofPid,
  input wire logic selfTuning,
  input wire logic heatCool,
  input wire logic followWrite,
  input wire logic followValue,
  input wire logic localWrite,
  input wire logic signed [smv_pkg::SP_W-1:0] localValue,
  input wire logic signed [smv_pkg::MV_W-1:0] handOutputValue,
  input wire logic signed [smv_pkg::MV_W-1:0] haltedOutputValue,
  input wire logic signed [smv_pkg::MV_W-1:0] faultOutputValue,
  input wire logic signed [smv_pkg::MV_W-1:0] outputCeiling,
  input wire logic signed [smv_pkg::MV_W-1:0] outputFloor,
  // Process inputs
  input wire logic signed [smv_pkg::SP_W-1:0] remoteSetpointValue,
  input wire logic signed [smv_pkg::MV_W-1:0] controlResult,
  input wire logic pvError,
  input wire logic remoteError,
  // Set-point results
  output logic signed [smv_pkg::SP_W-1:0] workingSetpoint,
  output logic signed [smv_pkg::SP_W-1:0] localSetpoint,
  output logic setpointFollowEnable,
  output logic remoteActive,
  output logic rampRequest,
  // Output results
  output logic signed [smv_pkg::MV_W-1:0] manipulatedOutput,
  output logic signed [smv_pkg::MV_W-1:0] heatDrive,
  output logic signed [smv_pkg::MV_W-1:0] coolDrive,
  output logic handActive,
  output logic periodTick
);

  localparam int CW = (PERIOD_CYC > 1) ? $clog2(PERIOD_CYC) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(PERIOD_CYC - 1);
  localparam bit FOLLOW_OK = (CHANNEL == 1) || (FOUR_CH && (CHANNEL == 2));

  smv_lim_if limBus ();

  smv_out_limit smv_out_limit_inst (
    .lim(limBus.lim)
  );

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_periodTick;
  logic [2:0] syncSrc;
  logic [2:0] next_syncSrc;
  logic [2:0] syncHand;
  logic [2:0] next_syncHand;
  logic srcFilt;
  logic next_srcFilt;
  logic handFilt;
  logic next_handFilt;
  logic signed [smv_pkg::SP_W-1:0] localSetpointPrior;
  logic signed [smv_pkg::SP_W-1:0] next_localSetpointPrior;
  logic signed [smv_pkg::SP_W-1:0] next_localSetpoint;
  logic signed [smv_pkg::SP_W-1:0] next_workingSetpoint;
  logic next_setpointFollowEnable;
  logic next_remoteActive;
  logic next_rampRequest;
  logic next_handActive;
  logic signed [smv_pkg::MV_W-1:0] next_manipulatedOutput;
  logic signed [smv_pkg::MV_W-1:0] next_heatDrive;
  logic signed [smv_pkg::MV_W-1:0] next_coolDrive;
  logic wantRemote;
  logic wantHand;
  logic followEff;
  logic signed [smv_pkg::MV_W-1:0] mvLo;
  logic signed [smv_pkg::MV_W-1:0] mvHi;
  logic signed [smv_pkg::MV_W-1:0] handSat;
  logic signed [smv_pkg::MV_W-1:0] haltedSat;
  logic signed [smv_pkg::MV_W-1:0] faultSat;

  assign limBus.raw = controlResult;
  assign limBus.ceiling = outputCeiling;
  assign limBus.floor = outputFloor;
  assign limBus.heatCool = heatCool;

  always_comb
  begin
    // Period counter
    next_cnt = (cnt == CNT_LAST) ? '0 : cnt + 1'b1;
    next_periodTick = (cnt == CNT_LAST);
    // Synchronisers: accept a change once stages two and three agree
    next_syncSrc = {syncSrc[1:0], evtSourcePin};
    next_syncHand = {syncHand[1:0], evtHandPin};
    next_srcFilt = (syncSrc[1] == syncSrc[2]) ? syncSrc[2] : srcFilt;
    next_handFilt = (syncHand[1] == syncHand[2]) ? syncHand[2] : handFilt;
    // Requested source and mode
    wantRemote = remoteEnable && (evtSourceAssigned ? srcFilt : cmdRemote);
    wantHand = evtHandAssigned ? handFilt : cmdHand;
    followEff = setpointFollowEnable && remoteEnable && FOLLOW_OK;
    // Override ranges
    mvLo = heatCool ? smv_pkg::MV_HC_MIN : smv_pkg::MV_STD_MIN;
    mvHi = heatCool ? smv_pkg::MV_HC_MAX : smv_pkg::MV_STD_MAX;
    handSat = smv_pkg::sat(handOutputValue, mvLo, mvHi);
    haltedSat = smv_pkg::sat(haltedOutputValue, mvLo, mvHi);
    faultSat = smv_pkg::sat(faultOutputValue, mvLo, mvHi);
    // Hold by default, except the ramp request, which pulses
    next_setpointFollowEnable = setpointFollowEnable;
    next_localSetpoint = localSetpoint;
    next_localSetpointPrior = localSetpointPrior;
    next_workingSetpoint = workingSetpoint;
    next_remoteActive = remoteActive;
    next_rampRequest = 1'b0;
    next_handActive = handActive;
    next_manipulatedOutput = manipulatedOutput;
    next_heatDrive = heatDrive;
    next_coolDrive = coolDrive;
    // Tracking setting accepted only while stopped
    if (followWrite && !runCmd)
    begin
      next_setpointFollowEnable = followValue;
    end
    if (localWrite)
    begin
      next_localSetpoint = localValue;
    end
    if (periodTick)
    begin
      next_handActive = wantHand;
      if (!remoteActive && wantRemote)
      begin
        next_remoteActive = 1'b1;
        next_localSetpointPrior = next_localSetpoint;
        next_rampRequest = rampEnable && runCmd;
      end
      else if (remoteActive && !wantRemote)
      begin
        next_remoteActive = 1'b0;
        if (followEff)
        begin
          next_localSetpoint = remoteSetpointValue;
        end
        else
        begin
          next_localSetpoint = localSetpointPrior;
        end
      end
      // Remote source tracks the remote channel value live
      next_workingSetpoint = next_remoteActive ? remoteSetpointValue
                                               : next_localSetpoint;
      // Output selection, overrides skip the limiter
      if (!twoDofPid)
      begin
        next_manipulatedOutput = controlResult;
      end
      else if (wantHand)
      begin
        next_manipulatedOutput = handSat;
      end
      else if (!runCmd)
      begin
        next_manipulatedOutput = haltedSat;
      end
      else if (pvError || remoteError)
      begin
        next_manipulatedOutput = faultSat;
      end
      else if (selfTuning)
      begin
        next_manipulatedOutput = controlResult;
      end
      else
      begin
        next_manipulatedOutput = limBus.result;
      end
      // In heat/cool mode negative drives cooling, positive heating; otherwise all goes to heating
      if (heatCool)
      begin
        next_heatDrive = (next_manipulatedOutput > 0) ? next_manipulatedOutput : '0;
        next_coolDrive = (next_manipulatedOutput < 0) ? -next_manipulatedOutput : '0;
      end
      else
      begin
        next_heatDrive = next_manipulatedOutput;
        next_coolDrive = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      periodTick <= 1'b0;
      syncSrc <= 3'h0;
      syncHand <= 3'h0;
      srcFilt <= 1'b0;
      handFilt <= 1'b0;
      setpointFollowEnable <= smv_pkg::FOLLOW_RST;
      localSetpoint <= smv_pkg::SP_RST;
      localSetpointPrior <= smv_pkg::SP_RST;
      workingSetpoint <= smv_pkg::SP_RST;
      remoteActive <= 1'b0;
      rampRequest <= 1'b0;
      handActive <= 1'b0;
      manipulatedOutput <= smv_pkg::MV_RST;
      heatDrive <= smv_pkg::MV_RST;
      coolDrive <= smv_pkg::MV_RST;
    end
    else
    begin
      cnt <= next_cnt;
      periodTick <= next_periodTick;
      syncSrc <= next_syncSrc;
      syncHand <= next_syncHand;
      srcFilt <= next_srcFilt;
      handFilt <= next_handFilt;
      setpointFollowEnable <= next_setpointFollowEnable;
      localSetpoint <= next_localSetpoint;
      localSetpointPrior <= next_localSetpointPrior;
      workingSetpoint <= next_workingSetpoint;
      remoteActive <= next_remoteActive;
      rampRequest <= next_rampRequest;
      handActive <= next_handActive;
      manipulatedOutput <= next_manipulatedOutput;
      heatDrive <= next_heatDrive;
      coolDrive <= next_coolDrive;
    end
  end

  property p_outOnTick;
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(manipulatedOutput) |-> $past(periodTick);
  endproperty
  a_outOnTick: assert property (p_outOnTick) else $error("output moved off tick");

  property p_srcEvent;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && remoteEnable && evtSourceAssigned |=> remoteActive == $past(srcFilt);
  endproperty
  a_srcEvent: assert property (p_srcEvent) else $error("source not from event");

  property p_remoteFollow;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && wantRemote |=> workingSetpoint == $past(remoteSetpointValue);
  endproperty
  a_remoteFollow: assert property (p_remoteFollow) else $error("remote not followed");

  property p_trackCopy;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && remoteActive && !wantRemote && followEff
      |=> localSetpoint == $past(remoteSetpointValue) && !remoteActive;
  endproperty
  a_trackCopy: assert property (p_trackCopy) else $error("tracking copy missed");

  property p_restore;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && remoteActive && !wantRemote && !followEff
      |=> localSetpoint == $past(localSetpointPrior);
  endproperty
  a_restore: assert property (p_restore) else $error("prior local not restored");

  property p_followLock;
    @(posedge ref_clk) disable iff (!rst_n)
    runCmd |=> setpointFollowEnable == $past(setpointFollowEnable);
  endproperty
  a_followLock: assert property (p_followLock) else $error("tracking written while run");

  property p_handPrio;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && twoDofPid && wantHand |=> manipulatedOutput == $past(handSat) && handActive;
  endproperty
  a_handPrio: assert property (p_handPrio) else $error("manual value not chosen");

  property p_halted;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && twoDofPid && !wantHand && !runCmd |=> manipulatedOutput == $past(haltedSat);
  endproperty
  a_halted: assert property (p_halted) else $error("stop value not chosen");

  property p_fault;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && twoDofPid && !wantHand && runCmd && (pvError || remoteError)
      |=> manipulatedOutput == $past(faultSat);
  endproperty
  a_fault: assert property (p_fault) else $error("error value not chosen");

  property p_clamp;
    @(posedge ref_clk) disable iff (!rst_n)
    periodTick && twoDofPid && !selfTuning && !wantHand && runCmd && !pvError && !remoteError
      |=> manipulatedOutput <= $past(limBus.hi) && manipulatedOutput >= $past(limBus.lo);
  endproperty
  a_clamp: assert property (p_clamp) else $error("output outside limits");

  property p_ramp;
    @(posedge ref_clk) disable iff (!rst_n)
    rampRequest |-> remoteActive && !$past(remoteActive) ##1 !rampRequest;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp request misplaced");

endmodule // smv_select

// ==== dv/smv_evt_model.sv ====
// Purpose: Far-side model driving the two event input pins
// Assumes: Requests come from the bench as levels on ref_clk
// Notes: Pins change just after a rising edge, like a slow field contact
`timescale 1ns/1ps
module smv_evt_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Requested levels
  input wire logic wantRemote,
  input wire logic wantHand,
  // Event pins
  output logic evtSourcePin,
  output logic evtHandPin
);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evtSourcePin <= 1'b0;
      evtHandPin <= 1'b0;
    end
    else
    begin
      evtSourcePin <= wantRemote;
      evtHandPin <= wantHand;
    end
  end
endmodule // smv_evt_model

// ==== dv/test_smv_select.sv ====
// Purpose: Self-checking bench for set-point and output selection
// Assumes: Short control period of 8 cycles
// Notes: Output rows in a table, set-point sequence hand-written
`timescale 1ns/1ps
module test_smv_select;
  typedef struct {
    logic hand, run, pe, re, two, st, hc;
    logic signed [15:0] ceil, flr, ctrl, mv;
  } smv_row_t;
  logic ref_clk = 1'b0, rst_n = 1'b0, wantRemote = 1'b0, wantHand = 1'b0;
  logic evtSourcePin, evtHandPin;
  logic evtSourceAssigned = 1'b0, evtHandAssigned = 1'b0, cmdRemote = 1'b0, cmdHand = 1'b0;
  logic runCmd = 1'b1, remoteEnable = 1'b0, rampEnable = 1'b0, twoDofPid = 1'b1;
  logic selfTuning = 1'b0, heatCool = 1'b0, followWrite = 1'b0, followValue = 1'b0;
  logic localWrite = 1'b0, pvError = 1'b0, remoteError = 1'b0;
  logic signed [15:0] localValue = 16'sh0000, remoteSetpointValue = 16'sh0000;
  logic signed [15:0] handOutputValue = 16'sh0064, haltedOutputValue = 16'shFFE2;
  logic signed [15:0] faultOutputValue = 16'sh01F4, controlResult = 16'sh0000;
  logic signed [15:0] outputCeiling = 16'sh041A, outputFloor = 16'shFBE6;
  logic signed [15:0] workingSetpoint, localSetpoint, manipulatedOutput, heatDrive, coolDrive;
  logic setpointFollowEnable, remoteActive, rampRequest, handActive, periodTick;
  int mismatches = 0;
  int checks_done = 0;
  smv_row_t rows [12] = '{
    '{0, 1, 0, 0, 1, 0, 0, 16'sh0320, 16'sh0064, 16'sh012C, 16'sh012C},
    '{0, 1, 0, 0, 1, 0, 0, 16'sh0320, 16'sh0064, 16'sh0384, 16'sh0320},
    '{0, 1, 0, 0, 1, 0, 0, 16'sh0320, 16'sh0064, 16'sh0032, 16'sh0064},
    '{0, 1, 0, 0, 1, 0, 0, 16'sh00C8, 16'sh0384, 16'sh03B6, 16'sh0384},
    '{1, 0, 1, 1, 1, 0, 0, 16'sh0032, 16'sh0000, 16'sh0384, 16'sh0064},
    '{0, 0, 1, 1, 1, 0, 0, 16'sh0032, 16'sh0000, 16'sh0384, 16'shFFE2},
    '{0, 1, 1, 0, 1, 0, 0, 16'sh0032, 16'sh0000, 16'sh0384, 16'sh01F4},
    '{0, 1, 0, 1, 1, 0, 0, 16'sh0032, 16'sh0000, 16'sh0384, 16'sh01F4},
    '{0, 1, 0, 0, 1, 1, 0, 16'sh0320, 16'sh0064, 16'sh0384, 16'sh0384},
    '{1, 1, 0, 0, 0, 0, 0, 16'sh0320, 16'sh0064, 16'sh0384, 16'sh0384},
    '{0, 1, 0, 0, 1, 0, 1, 16'sh041A, 16'shFBE6, 16'shFD44, 16'shFD44},
    '{0, 1, 0, 0, 1, 0, 1, 16'sh012C, 16'shFF38, 16'shFC7C, 16'shFF38}
  };
  smv_select #(.PERIOD_CYC(8), .CHANNEL(1), .FOUR_CH(1'b1)) smv_select_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evtSourcePin(evtSourcePin),
    .evtHandPin(evtHandPin),
    .evtSourceAssigned(evtSourceAssigned),
    .evtHandAssigned(evtHandAssigned),
    .cmdRemote(cmdRemote),
    .cmdHand(cmdHand),
    .runCmd(runCmd),
    .remoteEnable(remoteEnable),
    .rampEnable(rampEnable),
    .twoDofPid(twoDofPid),
    .selfTuning(selfTuning),
    .heatCool(heatCool),
    .followWrite(followWrite),
    .followValue(followValue),
    .localWrite(localWrite),
    .localValue(localValue),
    .handOutputValue(handOutputValue),
    .haltedOutputValue(haltedOutputValue),
    .faultOutputValue(faultOutputValue),
    .outputCeiling(outputCeiling),
    .outputFloor(outputFloor),
    .remoteSetpointValue(remoteSetpointValue),
    .controlResult(controlResult),
    .pvError(pvError),
    .remoteError(remoteError),
    .workingSetpoint(workingSetpoint),
    .localSetpoint(localSetpoint),
    .setpointFollowEnable(setpointFollowEnable),
    .remoteActive(remoteActive),
    .rampRequest(rampRequest),
    .manipulatedOutput(manipulatedOutput),
    .heatDrive(heatDrive),
    .coolDrive(coolDrive),
    .handActive(handActive),
    .periodTick(periodTick)
  );
  smv_evt_model smv_evt_model_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wantRemote(wantRemote),
    .wantHand(wantHand),
    .evtSourcePin(evtSourcePin),
    .evtHandPin(evtHandPin)
  );
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Wait for a tick, then let the one edge that samples it and updates the outputs pass
  task automatic upd();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (periodTick !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 40)
    begin
      chk("periodTick", {15'h0, periodTick}, 16'h0001);
    end
    @(posedge ref_clk);
    #1;
    chk("periodTickPulse", {15'h0, periodTick}, 16'h0000);
  endtask
  task automatic close_out();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1;
    chk("mvInReset", manipulatedOutput, 16'h0000);
    chk("followInReset", {15'h0, setpointFollowEnable}, 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      cmdHand <= rows[i].hand;
      runCmd <= rows[i].run;
      pvError <= rows[i].pe;
      remoteError <= rows[i].re;
      twoDofPid <= rows[i].two;
      selfTuning <= rows[i].st;
      heatCool <= rows[i].hc;
      outputCeiling <= rows[i].ceil;
      outputFloor <= rows[i].flr;
      controlResult <= rows[i].ctrl;
      upd();
      chk("manipulatedOutput", manipulatedOutput, rows[i].mv);
      chk("handActive", {15'h0, handActive}, {15'h0, rows[i].hand});
    end
    @(posedge ref_clk);
    runCmd <= 1'b0;
    upd();
    chk("coolDrive", coolDrive, 16'sh001E);
    chk("heatDrive", heatDrive, 16'sh0000);
    heatCool <= 1'b0;
    followWrite <= 1'b1;
    followValue <= 1'b1;
    runCmd <= 1'b1;
    @(posedge ref_clk);
    followWrite <= 1'b0;
    upd();
    chk("followWhileRun", {15'h0, setpointFollowEnable}, 16'h0000);
    runCmd <= 1'b0;
    followWrite <= 1'b1;
    localWrite <= 1'b1;
    localValue <= 16'sh0064;
    @(posedge ref_clk);
    followWrite <= 1'b0;
    localWrite <= 1'b0;
    upd();
    chk("followStopped", {15'h0, setpointFollowEnable}, 16'h0001);
    chk("localWorking", workingSetpoint, 16'sh0064);
    remoteEnable <= 1'b1;
    remoteSetpointValue <= 16'sh02BC;
    cmdRemote <= 1'b1;
    upd();
    chk("remoteWorking", workingSetpoint, 16'sh02BC);
    chk("remoteActive", {15'h0, remoteActive}, 16'h0001);
    remoteSetpointValue <= 16'sh02EE;
    upd();
    chk("remoteFollow", workingSetpoint, 16'sh02EE);
    cmdRemote <= 1'b0;
    upd();
    chk("trackedLocal", localSetpoint, 16'sh02EE);
    chk("trackedWorking", workingSetpoint, 16'sh02EE);
    followWrite <= 1'b1;
    followValue <= 1'b0;
    remoteSetpointValue <= 16'sh0258;
    cmdRemote <= 1'b1;
    @(posedge ref_clk);
    followWrite <= 1'b0;
    upd();
    cmdRemote <= 1'b0;
    upd();
    chk("restoredWorking", workingSetpoint, 16'sh02EE);
    runCmd <= 1'b1;
    rampEnable <= 1'b1;
    cmdRemote <= 1'b1;
    upd();
    chk("rampRequest", {15'h0, rampRequest}, 16'h0001);
    @(posedge ref_clk);
    #1;
    chk("rampRequestEnd", {15'h0, rampRequest}, 16'h0000);
    cmdRemote <= 1'b0;
    upd();
    evtSourceAssigned <= 1'b1;
    evtHandAssigned <= 1'b1;
    wantRemote <= 1'b1;
    wantHand <= 1'b1;
    upd();
    upd();
    chk("pinRemote", {15'h0, remoteActive}, 16'h0001);
    chk("pinHand", {15'h0, handActive}, 16'h0001);
    chk("pinHandMv", manipulatedOutput, 16'sh0064);
    wantHand <= 1'b0;
    wantRemote <= 1'b0;
    upd();
    upd();
    chk("pinAuto", {15'h0, handActive}, 16'h0000);
    chk("pinLocal", {15'h0, remoteActive}, 16'h0000);
    // Out-of-range manual value saturates to the standard maximum
    evtHandAssigned <= 1'b0;
    cmdHand <= 1'b1;
    handOutputValue <= 16'sh0500;
    upd();
    chk("handSaturated", manipulatedOutput, 16'sh041A);
    chk("heatDriveStd", heatDrive, 16'sh041A);
    chk("coolDriveStd", coolDrive, 16'sh0000);
    close_out();
  end
endmodule // test_smv_select
